// [shared/tapg_params.svh]
// constants of the two-axis pulse output guard
// What this block does
// - card decodes base address from its slot
// - per-axis format: dual pulses or pulse-direction
// - first output forward pulses or all pulses, second reverse/direction
// - per-axis direction polarity, one reverses output
// - per-axis hold output follows its setting
// - forward X limit stops forward X only
// - backward X limit stops backward X only
// - forward Y limit stops forward Y only
// - backward Y limit stops backward Y only
// - emergency input stops both axes entirely
// - one polarity setting for all switch inputs
`ifndef TAPG_PARAMS_SVH
`define TAPG_PARAMS_SVH

// ----------------------------------------
// slot decode
// ----------------------------------------
`define TAPG_BASE_LO 12'h080
`define TAPG_BASE_HI 12'h140
`define TAPG_SLOT_LSB 5

// ----------------------------------------
// register word index within the card window
// ----------------------------------------
`define TAPG_IDX_CTRL 3'h0
`define TAPG_IDX_CMD 3'h1
`define TAPG_IDX_STATUS 3'h2
`define TAPG_IDX_ISTAT 3'h3
`define TAPG_IDX_IMASK 3'h4

// ----------------------------------------
// field layout
// ----------------------------------------
`define TAPG_CTRL_FMT_LSB 0
`define TAPG_CTRL_INV_LSB 2
`define TAPG_CTRL_HOLD_LSB 4
`define TAPG_CTRL_POL_BIT 6
`define TAPG_CTRL_W 7
`define TAPG_CTRL_RST 7'h00
`define TAPG_CMD_CNT_W 16
`define TAPG_CMD_DIR_BIT 16
`define TAPG_CMD_AXIS_BIT 17
`define TAPG_EV_DONE_LSB 0
`define TAPG_EV_LIM_LSB 2
`define TAPG_EV_EMG_BIT 4
`define TAPG_EV_W 5
`define TAPG_ST_SW_LSB 8
`define TAPG_SW_N 7
`define TAPG_SW_EMG 6
`define TAPG_SYNC_W 11

// ----------------------------------------
// timing: 125 cycles of 4 ns give a 500 ns pulse tick
// ----------------------------------------
`define TAPG_TICK_DIV 8'h7D

`endif

// [shared/tapg_pkg.sv]
// types of the two-axis pulse output guard
package tapg_pkg;
    // pulse generator phase of one axis
    typedef enum logic [1:0] {PH_IDLE, PH_HIGH, PH_LOW} tapg_ph_t;
endpackage

// [shared/tapg_axis_if.sv]
// link between the register side and one axis pulse engine
`timescale 1ns/10ps
`default_nettype none
`include "tapg_params.svh"
interface tapg_axis_if;
    logic fmt; // one selects pulse-direction
    logic dir_inv; // reverse physical direction
    logic tick; // pulse rate enable
    logic start; // one-cycle command strobe
    logic cmd_dir; // one is forward
    logic [`TAPG_CMD_CNT_W-1:0] cmd_cnt; // pulses to send
    logic fwd_lim; // forward limit active
    logic back_lim; // backward limit active
    logic emg; // emergency active
    logic busy; // command running
    logic done; // pulse: count ran out
    logic lim_stop; // pulse: stopped by a limit
    logic out1; // forward pulse or all pulses
    logic out2; // reverse pulse or direction
    modport ctl (output fmt, dir_inv, tick, start, cmd_dir, cmd_cnt, fwd_lim, back_lim, emg,
                 input busy, done, lim_stop, out1, out2);
    modport ax (input fmt, dir_inv, tick, start, cmd_dir, cmd_cnt, fwd_lim, back_lim, emg,
                output busy, done, lim_stop, out1, out2);
endinterface
`default_nettype wire

// [verilog/tapg_axis.sv]
// pulse engine and limit guard of one axis
`timescale 1ns/10ps
`default_nettype none
`include "tapg_params.svh"
module tapg_axis (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register side
    tapg_axis_if.ax bus
);
    import tapg_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    tapg_ph_t ph_q, ph_d; // pulse phase
    logic [`TAPG_CMD_CNT_W-1:0] cnt_q, cnt_d; // pulses left
    logic dir_q, dir_d; // commanded direction, one forward
    logic out1_q, out2_q; // registered pin levels
    logic done_d, lim_d; // event pulses

    // blocking is judged on the commanded direction, so the far limit never blocks
    wire logic busy = (ph_q != PH_IDLE);
    wire logic fwd_blk = dir_q & bus.fwd_lim;
    wire logic back_blk = ~dir_q & bus.back_lim;
    wire logic blocked = bus.emg | fwd_blk | back_blk;
    wire logic last = (cnt_q == `TAPG_CMD_CNT_W'(1));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        ph_d = ph_q;
        cnt_d = cnt_q;
        dir_d = dir_q;
        done_d = 1'b0;
        lim_d = 1'b0;
        if (!busy) begin
            // new command only while idle; a zero count or an emergency refuses it
            if (bus.start && bus.cmd_cnt != '0 && !bus.emg) begin
                ph_d = PH_LOW;
                cnt_d = bus.cmd_cnt;
                dir_d = bus.cmd_dir;
            end
        end else if (blocked) begin
            // stop at once and drop the rest of the count
            ph_d = PH_IDLE;
            cnt_d = '0;
            lim_d = ~bus.emg;
        end else if (bus.tick) begin
            unique case (ph_q)
                PH_LOW: begin
                    ph_d = PH_HIGH;
                end
                PH_HIGH: begin
                    cnt_d = cnt_q - `TAPG_CMD_CNT_W'(1);
                    ph_d = last ? PH_IDLE : PH_LOW;
                    done_d = last;
                end
                PH_IDLE: begin
                    ph_d = PH_IDLE;
                end
            endcase
        end
    end

    // pin mapping from the next phase so a blocked cycle already shows no pulse
    wire logic pls = (ph_d == PH_HIGH);
    wire logic cw = dir_d ^ bus.dir_inv;
    wire logic out1_d = bus.fmt ? pls : (pls & cw);
    wire logic out2_d = bus.fmt ? cw : (pls & ~cw);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ph_q <= PH_IDLE;
            cnt_q <= '0;
            dir_q <= 1'b1;
            out1_q <= 1'b0;
            out2_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            out1_q <= out1_d;
            out2_q <= out2_d;
        end
    end

    assign bus.busy = busy;
    assign bus.done = done_d;
    assign bus.lim_stop = lim_d;
    assign bus.out1 = out1_q;
    assign bus.out2 = out2_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_fwd_block;
        @(posedge clk_i) disable iff (rst_i)
        busy && dir_q && bus.fwd_lim |=> ph_q == PH_IDLE && !(bus.fmt ? out1_q : out1_q | out2_q);
    endproperty
    a_fwd_block: assert property (p_fwd_block) else $error("forward limit did not stop axis");

    property p_back_block;
        @(posedge clk_i) disable iff (rst_i)
        busy && !dir_q && bus.back_lim |=> ph_q == PH_IDLE && cnt_q == '0;
    endproperty
    a_back_block: assert property (p_back_block) else $error("backward limit did not stop");

    property p_back_allowed;
        @(posedge clk_i) disable iff (rst_i)
        !busy && bus.start && bus.cmd_cnt != '0 && !bus.cmd_dir ##1
        (bus.fwd_lim && !bus.back_lim && !bus.emg) |-> busy;
    endproperty
    a_back_allowed: assert property (p_back_allowed) else $error("backward move was blocked");

    property p_emg_stop;
        @(posedge clk_i) disable iff (rst_i)
        bus.emg |=> !busy && !bus.out1 ##1 (!busy || !$past(bus.emg));
    endproperty
    a_emg_stop: assert property (p_emg_stop) else $error("emergency left axis running");

    property p_dir_level;
        @(posedge clk_i) disable iff (rst_i)
        busy && !blocked && bus.fmt && $stable(bus.dir_inv) |=> out2_q == (dir_q ^ bus.dir_inv);
    endproperty
    a_dir_level: assert property (p_dir_level) else $error("direction level wrong");

    property p_dual_excl;
        @(posedge clk_i) disable iff (rst_i)
        !bus.fmt && $stable(bus.fmt) |=> !(out1_q && out2_q);
    endproperty
    a_dual_excl: assert property (p_dual_excl) else $error("both pulse trains high");
endmodule
`default_nettype wire

// [verilog/tapg_top.sv]
// two-axis pulse output guard: bus slave, switch conditioning, axes
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tapg_params.svh"
module tapg_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // interrupt
    output logic irq_o,
    // slot straps
    input wire logic [2:0] slot_i,
    input wire logic eight_slot_i,
    // switch inputs, raw pin levels
    input wire logic x_back_limit_n_i,
    input wire logic x_fwd_limit_n_i,
    input wire logic x_home_n_i,
    input wire logic y_back_limit_n_i,
    input wire logic y_fwd_limit_n_i,
    input wire logic y_home_n_i,
    input wire logic emergency_n_i,
    // x axis outputs
    output logic x_fwd_pulse_out_o,
    output logic x_rev_or_dir_out_o,
    output logic x_hold_out_o,
    // y axis outputs
    output logic y_fwd_pulse_out_o,
    output logic y_rev_or_dir_out_o,
    output logic y_hold_out_o
);
    import tapg_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    // all switch pins, straps included, pass two flops before use; the bus inputs are used directly
    wire logic [`TAPG_SYNC_W-1:0] raw = {eight_slot_i, slot_i, emergency_n_i,
        y_home_n_i, y_fwd_limit_n_i, y_back_limit_n_i,
        x_home_n_i, x_fwd_limit_n_i, x_back_limit_n_i};
    logic [`TAPG_SYNC_W-1:0] meta_q; // first stage, read only by sync_q
    logic [`TAPG_SYNC_W-1:0] sync_q; // second stage

    genvar s;
    generate
        for (s = 0; s < `TAPG_SYNC_W; s++) begin : g_sync
            // two-flop synchroniser per pin
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    meta_q[s] <= 1'b1;
                    sync_q[s] <= 1'b1;
                end else begin
                    meta_q[s] <= raw[s];
                    sync_q[s] <= meta_q[s];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [`TAPG_CTRL_W-1:0] ctrl_q; // formats, polarity, hold, switch sense
    logic [`TAPG_EV_W-1:0] istat_q; // sticky events
    logic [`TAPG_EV_W-1:0] imask_q; // event enables
    logic [1:0] hold_q; // hold pins
    logic irq_q; // interrupt pin
    logic emg_prev_q; // emergency edge detector

    // ----------------------------------------
    // switch polarity
    // ----------------------------------------
    // polarity zero: active when pulled to ground; one: active when open
    wire logic sw_pol = ctrl_q[`TAPG_CTRL_POL_BIT];
    wire logic [`TAPG_SW_N-1:0] sw_act = sync_q[`TAPG_SW_N-1:0] ~^ {`TAPG_SW_N{sw_pol}};
    wire logic emg_act = sw_act[`TAPG_SW_EMG];
    // the host is expected to set the polarity before its first move; a later
    // change is taken at once and may itself stop a running axis

    // ----------------------------------------
    // slot decode
    // ----------------------------------------
    // slots 0..3 from the low base, 4..7 from the high base, 0x20 apart
    wire logic [2:0] slot = sync_q[9:7];
    wire logic eight_slot = sync_q[10];
    wire logic [11:0] slot_ofs = 12'(slot[1:0]) << `TAPG_SLOT_LSB;
    wire logic [11:0] card_base = (slot[2] ? `TAPG_BASE_HI : `TAPG_BASE_LO) + slot_ofs;
    wire logic slot_ok = ~slot[2] | eight_slot; // high slots exist only on 8-slot chassis
    wire logic card_hit = slot_ok && (haddr_i[31:12] == 20'h00000)
        && (haddr_i[11:`TAPG_SLOT_LSB] == card_base[11:`TAPG_SLOT_LSB]);

    // ----------------------------------------
    // ahb-lite address phase
    // ----------------------------------------
    // zero wait states: every transfer is answered in its first data cycle
    wire logic acc = hsel_i && hready_i && htrans_i[1];
    wire logic [2:0] a_idx = haddr_i[4:2];
    logic wr_pend_q; // write data phase pending
    logic wr_hit_q; // that write hit this card
    logic [2:0] wr_idx_q; // word index of that write
    logic [31:0] rdata_q; // read data for the data phase

    // ----------------------------------------
    // axis links
    // ----------------------------------------
    tapg_axis_if ax_if[2] ();
    logic [7:0] div_q; // pulse tick divider
    wire logic tick = (div_q == `TAPG_TICK_DIV - 8'h01);
    logic [1:0] busy;
    logic [1:0] done;
    logic [1:0] lim_stop;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    wire logic wr_ok = wr_pend_q && wr_hit_q;
    wire logic we_ctrl = wr_ok && (wr_idx_q == `TAPG_IDX_CTRL);
    wire logic we_cmd = wr_ok && (wr_idx_q == `TAPG_IDX_CMD);
    wire logic we_istat = wr_ok && (wr_idx_q == `TAPG_IDX_ISTAT);
    wire logic we_imask = wr_ok && (wr_idx_q == `TAPG_IDX_IMASK);
    wire logic cmd_axis = hwdata_i[`TAPG_CMD_AXIS_BIT];

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    wire logic [31:0] st_word = {17'h00000, sw_act, 6'h00, busy};
    wire logic [31:0] rd_mux =
        (a_idx == `TAPG_IDX_CTRL) ? {25'h0000000, ctrl_q} :
        (a_idx == `TAPG_IDX_STATUS) ? st_word :
        (a_idx == `TAPG_IDX_ISTAT) ? {27'h0000000, istat_q} :
        (a_idx == `TAPG_IDX_IMASK) ? {27'h0000000, imask_q} :
        32'h00000000; // command word and unused words read zero

    // ----------------------------------------
    // events
    // ----------------------------------------
    wire logic emg_rise = emg_act & ~emg_prev_q;
    wire logic [`TAPG_EV_W-1:0] ev_set = {emg_rise, lim_stop, done};
    wire logic [`TAPG_EV_W-1:0] ev_clr = we_istat ? hwdata_i[`TAPG_EV_W-1:0] : '0;
    // a new event beats a clear landing in the same cycle
    wire logic [`TAPG_EV_W-1:0] istat_d = (istat_q & ~ev_clr) | ev_set;

    // ----------------------------------------
    // axis engines
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_axis
            // per-axis settings picked from the control word
            assign ax_if[g].fmt = ctrl_q[`TAPG_CTRL_FMT_LSB + g];
            assign ax_if[g].dir_inv = ctrl_q[`TAPG_CTRL_INV_LSB + g];
            assign ax_if[g].tick = tick;
            // one command word serves both axes, the axis bit picks one
            assign ax_if[g].start = we_cmd && (cmd_axis == 1'(g));
            assign ax_if[g].cmd_dir = hwdata_i[`TAPG_CMD_DIR_BIT];
            assign ax_if[g].cmd_cnt = hwdata_i[`TAPG_CMD_CNT_W-1:0];
            // limits per axis: back at 3g, forward at 3g+1
            assign ax_if[g].back_lim = sw_act[3 * g];
            assign ax_if[g].fwd_lim = sw_act[3 * g + 1];
            assign ax_if[g].emg = emg_act;
            assign busy[g] = ax_if[g].busy;
            assign done[g] = ax_if[g].done;
            assign lim_stop[g] = ax_if[g].lim_stop;

            tapg_axis u_axis (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .bus(ax_if[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // clocked logic
    // ----------------------------------------
    // bus address phase capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend_q <= 1'b0;
            wr_hit_q <= 1'b0;
            wr_idx_q <= 3'h0;
            rdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= acc && hwrite_i;
            wr_hit_q <= card_hit;
            wr_idx_q <= a_idx;
            // misses and writes leave zero on the read lanes
            rdata_q <= (acc && !hwrite_i && card_hit) ? rd_mux : 32'h00000000;
        end
    end

    // control and mask registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `TAPG_CTRL_RST; // sense starts normally open
            imask_q <= '0;
        end else begin
            if (we_ctrl) begin
                ctrl_q <= hwdata_i[`TAPG_CTRL_W-1:0];
            end
            if (we_imask) begin
                imask_q <= hwdata_i[`TAPG_EV_W-1:0];
            end
        end
    end

    // hold pins follow their control bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_q <= 2'h0;
        end else begin
            hold_q <= ctrl_q[`TAPG_CTRL_HOLD_LSB +: 2];
        end
    end

    // sticky status, interrupt and emergency edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat_q <= '0;
            irq_q <= 1'b0;
            emg_prev_q <= 1'b0;
        end else begin
            istat_q <= istat_d;
            irq_q <= |(istat_d & imask_q);
            emg_prev_q <= emg_act;
        end
    end

    // free-running pulse rate divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 8'h00;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign irq_o = irq_q;
    assign x_fwd_pulse_out_o = ax_if[0].out1;
    assign x_rev_or_dir_out_o = ax_if[0].out2;
    assign y_fwd_pulse_out_o = ax_if[1].out1;
    assign y_rev_or_dir_out_o = ax_if[1].out2;
    assign x_hold_out_o = hold_q[0];
    assign y_hold_out_o = hold_q[1];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_slot_read;
        @(posedge clk_i) disable iff (rst_i)
        acc && !hwrite_i && slot_ok && haddr_i[31:2] == 30'(card_base[11:2]) + 30'h2
        |=> hrdata_o[1:0] == $past(busy);
    endproperty
    a_slot_read: assert property (p_slot_read) else $error("status not seen at slot base");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        we_ctrl |=> ##1 x_hold_out_o == $past(hwdata_i[`TAPG_CTRL_HOLD_LSB], 2);
    endproperty
    a_hold: assert property (p_hold) else $error("hold pin does not follow setting");

    property p_emg_pins;
        @(posedge clk_i) disable iff (rst_i)
        emg_act |=> !(x_fwd_pulse_out_o || y_fwd_pulse_out_o);
    endproperty
    a_emg_pins: assert property (p_emg_pins) else $error("pulse during emergency");

    property p_polarity;
        @(posedge clk_i) disable iff (rst_i)
        !sw_pol && !sync_q[`TAPG_SW_EMG] |-> emg_act;
    endproperty
    a_polarity: assert property (p_polarity) else $error("grounded input not active");
endmodule
`default_nettype wire

// [tb/tapg_motor_model.sv]
// partner model: motor driver pulse counter and limit switch bank
`timescale 1ns/10ps
`default_nettype none
module tapg_motor_model (
    // clock and bench control
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic pol_i,
    input wire logic [6:0] act_i,
    input wire logic [1:0] fmt_i,
    // pulse pins from the card
    input wire logic [1:0] p1_i,
    input wire logic [1:0] p2_i,
    // switch pins and pulse counts
    output logic [6:0] pin_n_o,
    output logic [1:0][15:0] fwd_o,
    output logic [1:0][15:0] rev_o
);
    logic [1:0] p1_q = 2'h0; // last first-pin level
    logic [1:0] p2_q = 2'h0; // last second-pin level

    // active contact sits at the polarity level, idle contact at the other
    assign pin_n_o = pol_i ? act_i : ~act_i;

    // count physical steps; pulse-direction reads the level beside the pulse
    always @(posedge clk_i) begin
        p1_q <= p1_i;
        p2_q <= p2_i;
        for (int a = 0; a < 2; a++) begin
            if (clr_i) begin
                fwd_o[a] <= 16'h0;
                rev_o[a] <= 16'h0;
            end else if (p1_i[a] && !p1_q[a] && (!fmt_i[a] || p2_i[a])) begin
                fwd_o[a] <= fwd_o[a] + 16'h1;
            end else if (fmt_i[a] ? (p1_i[a] && !p1_q[a]) : (p2_i[a] && !p2_q[a])) begin
                rev_o[a] <= rev_o[a] + 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/tapg_top_test.sv]
// self-checking bench of the two-axis pulse output guard
`timescale 1ns/10ps
`default_nettype none
module tapg_top_test;
    // bus master, straps and bench state
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic clr = 1'b0;
    logic pol = 1'b0;
    logic dph = 1'b0;
    logic hready, hresp, irq, ph;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, base, snap;
    logic [1:0] htrans = 2'h0;
    logic [1:0] fmt = 2'h0;
    logic [1:0] p1, p2, hold, hv;
    logic [2:0] slot = 3'h0;
    logic [6:0] act = 7'h00;
    logic [6:0] pin_n;
    logic [15:0] n;
    logic [1:0][15:0] fwd, rev;
    logic [31:0] expq[$]; // expected read data, oldest first
    int fails = 0;
    int total_checks = 0;
    integer seed = 32'h440582CC;

    // 250 MHz clock
    initial forever #2 clk_i = ~clk_i;

    tapg_top uut (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .irq_o(irq),
        .slot_i(slot), .eight_slot_i(1'b1),
        .x_back_limit_n_i(pin_n[0]), .x_fwd_limit_n_i(pin_n[1]), .x_home_n_i(pin_n[2]),
        .y_back_limit_n_i(pin_n[3]), .y_fwd_limit_n_i(pin_n[4]), .y_home_n_i(pin_n[5]),
        .emergency_n_i(pin_n[6]),
        .x_fwd_pulse_out_o(p1[0]), .x_rev_or_dir_out_o(p2[0]), .x_hold_out_o(hold[0]),
        .y_fwd_pulse_out_o(p1[1]), .y_rev_or_dir_out_o(p2[1]), .y_hold_out_o(hold[1])
    );

    tapg_motor_model motor (
        .clk_i(clk_i), .clr_i(clr), .pol_i(pol), .act_i(act), .fmt_i(fmt), .p1_i(p1),
        .p2_i(p2), .pin_n_o(pin_n), .fwd_o(fwd), .rev_o(rev)
    );

    // one comparison, counted; a mismatch reports at once
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // card window base of a slot
    function automatic logic [31:0] slot_base(input int s);
        return (s < 4) ? 32'h080 + 32'(s) * 32'h020 : 32'h140 + 32'(s - 4) * 32'h020;
    endfunction

    // single word transfer: hold address phase, then data phase, each until ready
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
    endtask

    task automatic wr(input logic [31:0] o, input logic [31:0] d);
        bus(1'b1, base + o, d);
    endtask

    // read notes its expectation; the monitor compares in the data phase
    task automatic rd(input logic [31:0] o, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, base + o, 32'h0);
    endtask

    // monitor: data phase follows an accepted read address phase
    always @(posedge clk_i) dph <= hsel & htrans[1] & !hwrite & hready;
    always @(negedge clk_i) if (dph) chk("hrdata", expq.pop_front(), hrdata);

    // one command, wait for its event, check and clear it
    task automatic move(input logic a, input logic d, input logic [15:0] m, input logic [31:0] ev);
        int i;
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        wr(32'h04, {14'h0, a, d, m});
        for (i = 0; i < int'(m) * 400 + 200 && irq !== 1'b1; i++) @(posedge clk_i);
        chk("irq", 32'h1, {31'h0, irq});
        chk("hresp", 32'h0, {31'h0, hresp});
        rd(32'h0C, ev);
        wr(32'h0C, 32'h1F);
        repeat (130) @(posedge clk_i); // wait past one full 125-cycle tick; the run ends on its high tick
    endtask

    // verdict and end of run
    task automatic end_sim;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog: the full sequence needs about 10000 cycles
    initial begin
        repeat (80000) @(posedge clk_i);
        fails++;
        end_sim();
    end

    initial begin
        base = slot_base(0);
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // slot straps need two edges through the synchronisers before decode
        repeat (2) @(posedge clk_i);
        wr(32'h00, 32'h0);
        for (int o = 0; o < 24; o += 4) rd(o, 32'h0);
        // switch polarity: same contacts read active in both senses
        for (int p = 0; p < 2; p++) begin
            pol <= p[0];
            act <= 7'h2D;
            wr(32'h00, {25'h0, p[0], 6'h0});
            repeat (4) @(posedge clk_i);
            rd(32'h08, 32'h2D00);
        end
        pol <= 1'b0;
        act <= 7'h00;
        wr(32'h00, 32'h0);
        repeat (4) @(posedge clk_i);
        wr(32'h0C, 32'h1F);
        // every slot decodes its own window only; hold follows its setting
        for (int s = 0; s < 8; s++) begin
            slot <= s[2:0];
            base = slot_base(s);
            hv = 2'($random(seed));
            repeat (4) @(posedge clk_i);
            wr(32'h00, {26'h0, hv, 4'h0});
            rd(32'h00, {26'h0, hv, 4'h0});
            rd(slot_base((s + 1) % 8) - base, 32'h0);
            chk("hold", {30'h0, hv}, {30'h0, hold});
        end
        slot <= 3'h0;
        base = slot_base(0);
        repeat (4) @(posedge clk_i);
        wr(32'h10, 32'h1F);
        // every format, polarity and commanded direction on both axes
        for (int k = 0; k < 16; k++) begin
            fmt <= {k[2] ^ k[3], k[2]};
            n = 16'(1 + ($random(seed) & 1));
            wr(32'h00, {28'h0, k[1], k[1], k[2] ^ k[3], k[2]});
            move(k[3], k[0], n, 32'h1 << k[3]);
            ph = k[0] ^ k[1];
            chk("fwd", ph ? {16'h0, n} : 32'h0, {16'h0, fwd[k[3]]});
            chk("rev", ph ? 32'h0 : {16'h0, n}, {16'h0, rev[k[3]]});
        end
        fmt <= 2'h0;
        wr(32'h00, 32'h0);
        // each limit blocks only its own direction
        for (int k = 0; k < 4; k++) begin
            act <= 7'(7'h01 << (3 * k[1] + k[0]));
            repeat (4) @(posedge clk_i);
            move(k[1], k[0], 16'h1, 32'h4 << k[1]);
            chk("blocked", 32'h0, {16'h0, fwd[k[1]] | rev[k[1]]});
            move(k[1], !k[0], 16'h1, 32'h1 << k[1]);
            chk("freed", {31'h0, !k[0]}, {16'h0, fwd[k[1]]});
        end
        act <= 7'h00;
        // emergency in mid-run stops both axes
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        wr(32'h04, {14'h0, 2'b01, 16'h0064});
        wr(32'h04, {14'h0, 2'b10, 16'h0064});
        repeat (500) @(posedge clk_i);
        act <= 7'h40;
        repeat (20) @(posedge clk_i);
        rd(32'h0C, 32'h10);
        rd(32'h08, 32'h4000);
        snap = {fwd[0], rev[1]};
        chk("moved", 32'h1, {31'h0, fwd[0] != 16'h0 && rev[1] != 16'h0});
        repeat (400) @(posedge clk_i);
        chk("frozen", snap, {fwd[0], rev[1]});
        act <= 7'h00;
        // mask hides the event, clearing drops the line
        wr(32'h10, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("masked", 32'h0, {31'h0, irq});
        wr(32'h10, 32'h1F);
        repeat (2) @(posedge clk_i);
        chk("unmasked", 32'h1, {31'h0, irq});
        wr(32'h0C, 32'h1F);
        repeat (2) @(posedge clk_i);
        chk("cleared", 32'h0, {31'h0, irq});
        chk("pending", 32'h0, 32'(expq.size()));
        end_sim();
    end
endmodule
`default_nettype wire
